// ---- verilog/adc_regs_pkg.sv ----
// Purpose: shared constants and types for the serial register-access front end
// Assumes: 100 MHz system clock; serial clock sampled as an ordinary input
// Notes: register widths are in bits; offsets are register addresses
package adc_regs_pkg;
	localparam logic [5:0]  ADDR_COMMAND   = 6'h00;
	localparam logic [5:0]  ADDR_ADC_MODE  = 6'h01;
	localparam logic [5:0]  ADDR_IF_MODE   = 6'h02;
	localparam logic [5:0]  ADDR_ID        = 6'h07;
	localparam logic [5:0]  ADDR_CHANNEL0  = 6'h10;
	localparam logic [5:0]  ADDR_SETUP0    = 6'h20;
	localparam logic [5:0]  ADDR_FILTER0   = 6'h28;
	localparam logic [5:0]  ADDR_OFFSET0   = 6'h30;
	localparam logic [5:0]  ADDR_GAIN0     = 6'h38;
	localparam int          NUM_CHANNELS   = 16;
	localparam int          NUM_SETUPS     = 8;
	localparam logic [15:0] CHANNEL0_RESET = 16'h8001;
	localparam logic [15:0] CHANNELN_RESET = 16'h0001;
	localparam logic [15:0] SETUP_RESET    = 16'h1000;
	localparam logic [15:0] FILTER_RESET   = 16'h0500;
	localparam logic [15:0] ADC_MODE_RESET = 16'h2000;
	localparam logic [15:0] IF_MODE_RESET  = 16'h0000;
	localparam logic [23:0] OFFSET_RESET   = 24'h800000;
	localparam logic [23:0] GAIN_RESET     = 24'h500000;
	localparam int          CMD_NOWRITE_BIT = 7;
	localparam int          CMD_READ_BIT    = 6;
	localparam int          CH_ENABLE_BIT   = 15;
	localparam int          CH_SETUP_LSB    = 12;
	localparam int          CH_SETUP_W      = 3;
	localparam int          SETUP_POLARITY_BIT = 12;
	localparam int          SETUP_POS_REFBUF_BIT = 11;
	localparam int          SETUP_NEG_REFBUF_BIT = 10;
	localparam int          SETUP_INBUF_LSB = 8;
	localparam int          SETUP_REFSEL_LSB = 4;
	localparam int          ONES_FOR_RESET = 64;
	localparam logic [6:0]  ONES_COUNT_MAX = 7'h40;
	localparam logic [5:0]  BITS_CMD       = 6'h08;
	localparam logic [5:0]  BITS_8         = 6'h08;
	localparam logic [5:0]  BITS_16        = 6'h10;
	localparam logic [5:0]  BITS_24        = 6'h18;

	typedef enum logic [1:0] {
		REF_EXTERNAL,
		REF_RESERVED,
		REF_INTERNAL,
		REF_SUPPLY
	} reference_source_t;

	typedef struct packed {
		logic sclk;
		logic sdi;
		logic cs_n;
	} serial_in_t;

	typedef struct packed {
		logic        enable;
		logic [2:0]  setup;
		logic [9:0]  input_sel;
	} channel_view_t;
endpackage

// ---- verilog/adc_sync2.sv ----
// Purpose: two-flop synchroniser for a bundle of asynchronous levels
// Assumes: single destination clock
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module adc_sync2 #(
	parameter int          WIDTH = 3,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	always_comb begin
		next_state.meta   = i_async;
		next_state.stable = state.meta;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= {INIT, INIT};
		end else begin
			state <= next_state;
		end
	end

	assign o_sync = state.stable;
endmodule

// ---- verilog/adc_register_access_config.sv ----
// Purpose: serial command/data front end and configuration registers of the converter
// Assumes: serial clock idles high and is sampled by i_clk after two flops
// Notes: link clock must be slower than a quarter of i_clk; bench uses 80 ns
//
// Summary of operation
// [RULE1] an 8-bit write-only command byte opens every register transaction
// [RULE2] after any reset the interface waits for a command byte
// [RULE3] command bits 5:0 address the target register
// [RULE4] command bit 6 chooses read (one) or write (zero)
// [RULE5] host keeps command bit 7 low; commands with it set are ignored
// [RULE6] after the data phase the interface waits for a new command
// [RULE7] 64 serial clocks with data high reset the whole device
// [RULE8] chip select high aborts a transfer, registers are kept
// [RULE9] data length depends on register: 8/16/24 writes, up to 32 reads; reads here stop at 24 bits
// [RULE10] read-only 16-bit identity at 0x07, low nibble unspecified
// [RULE11] host issues a full reset after power-up and after lost sync
// [RULE12] channel 0 resets enabled, first pair, setup 0, value 0x8001
// [RULE13] setups reset with buffers off, external reference, value 0x1000
// [RULE14] filters reset to sinc5+sinc1 at the fastest rate
// [RULE15] mode resets to continuous conversion, internal oscillator, reference off
// [RULE16] CRC, status append and open wire detection reset off
// [RULE17] sixteen channel registers and eight setups, freely assignable
// [RULE18] channel: enable bit 15, setup select, 10-bit input selection
// [RULE19] sequencer walks enabled channels upward from 0 to 15, then repeats
// [RULE20] each setup has setup, filter, gain and offset registers
// [RULE21] setup holds polarity, two reference buffer enables, input buffer enables
// [RULE22] reference select picks external, internal or supply span
// [RULE23] filter register picks type, order and output rate
// [RULE24] SPI mode 3: drive on falling, sample on rising, select may be tied low
// [RULE25] channels and per-setup registers sit at consecutive addresses
`timescale 1ns/100ps
module adc_register_access_config
	import adc_regs_pkg::*;
#(
	parameter logic [15:0] ID_CODE = 16'h5a50
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_sclk,
	input  wire logic        i_sdi,
	input  wire logic        i_cs_n,
	input  wire logic        i_sample_done,
	output logic             o_sdo,
	output logic             o_sdo_oe_n,
	output logic             o_channel_valid,
	output logic [3:0]       o_active_channel,
	output logic [15:0]      o_active_setup,
	output logic [15:0]      o_active_filter,
	output logic             o_internal_ref_on,
	output logic             o_open_wire_on
);
	// ID_CODE default is arbitrary; low four bits read back as given
	typedef enum logic [1:0] {
		ST_COMMAND,
		ST_WRITE,
		ST_READ
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic        sclk_d;
		logic [5:0]  addr;
		logic [5:0]  bit_cnt;
		logic [5:0]  data_len;
		logic [31:0] shift;
		logic        sdo;
		logic [6:0]  ones_cnt;
		logic [NUM_CHANNELS*16-1:0] channel;
		logic [NUM_SETUPS*16-1:0]   setup;
		logic [NUM_SETUPS*16-1:0]   filter;
		logic [NUM_SETUPS*24-1:0]   offset;
		logic [NUM_SETUPS*24-1:0]   gain;
		logic [15:0] adc_mode;
		logic [15:0] if_mode;
		logic [3:0]  active;
	} core_state_t;

	core_state_t state;
	core_state_t next_state;
	serial_in_t  pins;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [31:0] read_word;
	logic [5:0]  read_len;
	logic [5:0]  write_len;
	logic        write_ok;
	logic [3:0]  seq_next;
	logic        seq_found;

	adc_sync2 #(
		.WIDTH (3),
		.INIT  (3'h7)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_sclk, i_sdi, i_cs_n}),
		.o_sync  (pins)
	);

	// edges seen on the sampled clock; idle-high means rise = sample edge
	assign sclk_rise = pins.sclk & ~state.sclk_d; // RULE24
	assign sclk_fall = ~pins.sclk & state.sclk_d; // RULE24

	function automatic core_state_t reset_image();
		core_state_t s;
		s = '0;
		s.phase    = ST_COMMAND; // RULE2
		s.sclk_d   = 1'b1;
		s.sdo      = 1'b1;
		s.adc_mode = ADC_MODE_RESET; // RULE15
		s.if_mode  = IF_MODE_RESET; // RULE16
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			s.channel[i*16 +: 16] = (i == 0) ? CHANNEL0_RESET : CHANNELN_RESET; // RULE12
		end
		for (int i = 0; i < NUM_SETUPS; i++) begin
			s.setup[i*16 +: 16]  = SETUP_RESET; // RULE13
			s.filter[i*16 +: 16] = FILTER_RESET; // RULE14
			s.offset[i*24 +: 24] = OFFSET_RESET;
			s.gain[i*24 +: 24]   = GAIN_RESET;
		end
		return s;
	endfunction

	// address decode: length and read value per register
	always_comb begin
		read_word = '0;
		read_len  = BITS_8;
		write_len = BITS_16;
		write_ok  = 1'b1;
		if (state.addr == ADDR_ADC_MODE) begin
			read_word = {state.adc_mode, 16'h0000};
		end else if (state.addr == ADDR_IF_MODE) begin
			read_word = {state.if_mode, 16'h0000};
		end else if (state.addr == ADDR_ID) begin
			read_word = {ID_CODE, 16'h0000}; // RULE10
			write_ok  = 1'b0;
		end else if (state.addr[5:4] == ADDR_CHANNEL0[5:4]) begin
			read_word = {state.channel[state.addr[3:0]*16 +: 16], 16'h0000}; // RULE25
		end else if (state.addr[5:3] == ADDR_SETUP0[5:3]) begin
			read_word = {state.setup[state.addr[2:0]*16 +: 16], 16'h0000}; // RULE20
		end else if (state.addr[5:3] == ADDR_FILTER0[5:3]) begin
			read_word = {state.filter[state.addr[2:0]*16 +: 16], 16'h0000}; // RULE23
		end else if (state.addr[5:3] == ADDR_OFFSET0[5:3]) begin
			read_word = {state.offset[state.addr[2:0]*24 +: 24], 8'h00};
			write_len = BITS_24;
		end else if (state.addr[5:3] == ADDR_GAIN0[5:3]) begin
			read_word = {state.gain[state.addr[2:0]*24 +: 24], 8'h00};
			write_len = BITS_24;
		end else begin
			// unmapped: one byte of zeros, writes discarded
			write_len = BITS_8;
			write_ok  = 1'b0;
		end
		if (state.addr != ADDR_ID && write_len == BITS_16 && write_ok) begin
			read_len = BITS_16;
		end else if (state.addr == ADDR_ID) begin
			read_len = BITS_16; // RULE9
		end else if (write_len == BITS_24) begin
			read_len = BITS_24;
		end
	end

	// next enabled channel above the active one, wrapping at 15
	always_comb begin
		seq_next  = state.active;
		seq_found = 1'b0;
		for (int k = 1; k <= NUM_CHANNELS; k++) begin
			if (!seq_found &&
			    state.channel[(4'(int'(state.active) + k))*16 + CH_ENABLE_BIT]) begin
				seq_next  = 4'(int'(state.active) + k); // RULE19
				seq_found = 1'b1;
			end
		end
	end

	always_comb begin
		next_state        = state;
		next_state.sclk_d = pins.sclk;

		// run of ones counted on sample edges; any zero restarts it
		if (sclk_rise) begin
			if (!pins.sdi) begin
				next_state.ones_cnt = '0;
			end else if (state.ones_cnt != ONES_COUNT_MAX) begin
				next_state.ones_cnt = state.ones_cnt + 7'h01; // RULE7
			end
		end

		if (i_sample_done && seq_found) begin
			next_state.active = seq_next; // RULE19
		end

		case (state.phase)
			ST_COMMAND: begin
				if (sclk_rise) begin
					next_state.shift   = {state.shift[30:0], pins.sdi};
					next_state.bit_cnt = state.bit_cnt + 6'h01;
					if (state.bit_cnt + 6'h01 == BITS_CMD) begin // RULE1
						next_state.bit_cnt = '0;
						next_state.addr    = state.shift[4:0] == 5'h1f && pins.sdi
							? 6'h3f : {state.shift[4:0], pins.sdi}; // RULE3
						if (state.shift[CMD_NOWRITE_BIT-1]) begin
							next_state.phase = ST_COMMAND; // RULE5
						end else if (state.shift[CMD_READ_BIT-1]) begin
							next_state.phase = ST_READ; // RULE4
						end else begin
							next_state.phase = ST_WRITE; // RULE4
						end
					end
				end
			end
			ST_WRITE: begin
				if (sclk_rise) begin
					next_state.shift   = {state.shift[30:0], pins.sdi};
					next_state.bit_cnt = state.bit_cnt + 6'h01;
					if (state.bit_cnt + 6'h01 == write_len) begin // RULE9
						next_state.phase   = ST_COMMAND; // RULE6
						next_state.bit_cnt = '0;
						if (write_ok) begin
							if (state.addr == ADDR_ADC_MODE) begin
								next_state.adc_mode = {state.shift[14:0], pins.sdi};
							end else if (state.addr == ADDR_IF_MODE) begin
								next_state.if_mode = {state.shift[14:0], pins.sdi};
							end else if (state.addr[5:4] == ADDR_CHANNEL0[5:4]) begin
								next_state.channel[state.addr[3:0]*16 +: 16] =
									{state.shift[14:0], pins.sdi}; // RULE17 RULE18
							end else if (state.addr[5:3] == ADDR_SETUP0[5:3]) begin
								next_state.setup[state.addr[2:0]*16 +: 16] =
									{state.shift[14:0], pins.sdi}; // RULE21
							end else if (state.addr[5:3] == ADDR_FILTER0[5:3]) begin
								next_state.filter[state.addr[2:0]*16 +: 16] =
									{state.shift[14:0], pins.sdi};
							end else if (state.addr[5:3] == ADDR_OFFSET0[5:3]) begin
								next_state.offset[state.addr[2:0]*24 +: 24] =
									{state.shift[22:0], pins.sdi};
							end else begin
								next_state.gain[state.addr[2:0]*24 +: 24] =
									{state.shift[22:0], pins.sdi};
							end
						end
					end
				end
			end
			ST_READ: begin
				// first falling edge after the command loads the word
				if (sclk_fall) begin
					if (state.bit_cnt == '0) begin
						next_state.shift = {read_word[30:0], 1'b0};
						next_state.sdo   = read_word[31];
					end else begin
						next_state.shift = {state.shift[30:0], 1'b0};
						next_state.sdo   = state.shift[31];
					end
				end
				if (sclk_rise) begin
					next_state.bit_cnt = state.bit_cnt + 6'h01;
					if (state.bit_cnt + 6'h01 == read_len) begin // RULE9
						next_state.phase   = ST_COMMAND; // RULE6
						next_state.bit_cnt = '0;
					end
				end
			end
			default: begin
				next_state.phase = ST_COMMAND;
			end
		endcase

		// chip select high: abandon the transfer, keep registers
		if (pins.cs_n) begin
			next_state.phase    = ST_COMMAND; // RULE8
			next_state.bit_cnt  = '0;
			next_state.ones_cnt = '0;
			next_state.sdo      = 1'b1;
		end

		// full reset once the run of ones is complete
		if (state.ones_cnt == ONES_COUNT_MAX) begin
			next_state        = reset_image(); // RULE7
			next_state.sclk_d = pins.sclk;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= reset_image(); // RULE2
		end else begin
			state <= next_state;
		end
	end

	// reference-select options: external, internal, supply span
	reference_source_t ref_sel;
	assign ref_sel = reference_source_t'(
		state.setup[state.channel[state.active*16 + CH_SETUP_LSB +: CH_SETUP_W]*16
		+ SETUP_REFSEL_LSB +: 2]); // RULE22

	assign o_sdo            = state.sdo;
	assign o_sdo_oe_n       = pins.cs_n; // RULE24
	assign o_channel_valid  = state.channel[state.active*16 + CH_ENABLE_BIT];
	assign o_active_channel = state.active;
	assign o_active_setup   =
		state.setup[state.channel[state.active*16 + CH_SETUP_LSB +: CH_SETUP_W]*16 +: 16];
	assign o_active_filter  =
		state.filter[state.channel[state.active*16 + CH_SETUP_LSB +: CH_SETUP_W]*16 +: 16];
	assign o_internal_ref_on = state.adc_mode[15] | (ref_sel == REF_INTERNAL);
	assign o_open_wire_on    = 1'b0; // RULE16
endmodule

// ---- tb/adc_register_access_config_chk.sv ----
// Purpose: port-level checks of the serial register front end
// Assumes: one clock domain, reset active high
// Notes: serial inputs pass two sync flops, so windows allow four clocks
`timescale 1ns/100ps
module adc_register_access_config_chk
	import adc_regs_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_sclk,
	input  wire logic        i_sdi,
	input  wire logic        i_cs_n,
	input  wire logic        i_sample_done,
	input  wire logic        o_sdo,
	input  wire logic        o_sdo_oe_n,
	input  wire logic        o_channel_valid,
	input  wire logic [3:0]  o_active_channel,
	input  wire logic [15:0] o_active_setup,
	input  wire logic [15:0] o_active_filter,
	input  wire logic        o_open_wire_on
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence deselected_s; i_cs_n [*4]; endsequence
	sequence selected_s; (!i_cs_n && !i_sdi) [*4]; endsequence
	sequence no_step_s; (!i_sample_done) [*4]; endsequence
	sequence quiet_s; (i_cs_n && i_sclk && !i_sample_done) [*6]; endsequence
	AST_RESET_VIEW: assert property ($fell(i_rst) |-> o_active_channel == 4'h0 &&
		o_channel_valid && o_active_setup == SETUP_RESET && o_active_filter == FILTER_RESET)
		else $error("reset view wrong");
	AST_SDO_IDLE: assert property (deselected_s |-> o_sdo)
		else $error("sdo not idle");
	AST_OE_IDLE: assert property (deselected_s |-> o_sdo_oe_n)
		else $error("sdo driven while deselected");
	AST_OE_SELECTED: assert property (selected_s |-> !o_sdo_oe_n)
		else $error("sdo not driven while selected");
	AST_OPEN_WIRE_OFF: assert property (o_open_wire_on == 1'b0)
		else $error("open wire on");
	AST_CH_HOLD: assert property (no_step_s |=>
		$stable(o_active_channel) || o_active_channel == 4'h0)
		else $error("channel moved without step");
	AST_CH_VALID: assert property (i_sample_done |-> ##[1:3] o_channel_valid)
		else $error("step landed on disabled channel");
	AST_SETUP_QUIET: assert property (quiet_s |=>
		$stable(o_active_setup) && $stable(o_active_filter))
		else $error("setup view moved while idle");
endmodule

bind adc_register_access_config adc_register_access_config_chk chk_inst (
	.i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_sdi(i_sdi), .i_cs_n(i_cs_n),
	.i_sample_done(i_sample_done), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
	.o_channel_valid(o_channel_valid), .o_active_channel(o_active_channel),
	.o_active_setup(o_active_setup), .o_active_filter(o_active_filter),
	.o_open_wire_on(o_open_wire_on)
);

// ---- tb/adc_host_model.sv ----
// Purpose: host master of the serial link
// Assumes: i_clk 100 MHz, link bit time eight clocks (80 ns)
// Notes: link clock stands high between frames
`timescale 1ns/100ps
module adc_host_model (
	input  wire logic i_clk,
	input  wire logic i_sdo,
	output logic      o_sclk,
	output logic      o_sdi,
	output logic      o_cs_n
);
	initial begin
		o_sclk = 1'b1;
		o_sdi  = 1'b1;
		o_cs_n = 1'b1;
	end
	task automatic sel(input logic on);
		@(posedge i_clk);
		o_cs_n <= ~on;
		repeat (8) @(posedge i_clk);
	endtask
	// drive on the fall, take sdo just after the rise while it still holds
	task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
		dout = '0;
		for (int i = n - 1; i >= 0; i--) begin
			o_sclk <= 1'b0;
			o_sdi  <= din[i];
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b1;
			@(negedge i_clk);
			dout = {dout[62:0], i_sdo};
			repeat (4) @(posedge i_clk);
		end
	endtask
endmodule

// ---- tb/adc_register_access_config_bench.sv ----
// Purpose: self-checking bench of the serial register front end
// Assumes: host model on the link, shadow copy of the register map
// Notes: reserved bits are kept clear in writes since their storage is open
`timescale 1ns/100ps
module adc_register_access_config_bench;
	import adc_regs_pkg::*;
	localparam logic [15:0] ID_VAL = 16'h6b20; // arbitrary value
	logic        i_clk, i_rst, i_sample_done, sclk, sdi, cs_n, sdo, oe_n, valid, iref, ow;
	logic [3:0]  act_ch;
	logic [15:0] act_setup, act_filter;
	logic [31:0] shadow [64];
	logic [63:0] rx;
	logic [5:0]  a;
	logic [5:0]  rlist [14] = '{6'h01, 6'h02, 6'h05, 6'h07, 6'h10, 6'h11, 6'h1f,
		6'h20, 6'h27, 6'h28, 6'h2f, 6'h30, 6'h38, 6'h3f};
	int          miscompares, n_tests;
	adc_register_access_config #(.ID_CODE(ID_VAL)) adc_register_access_config_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_sdi(sdi), .i_cs_n(cs_n),
		.i_sample_done(i_sample_done), .o_sdo(sdo), .o_sdo_oe_n(oe_n),
		.o_channel_valid(valid), .o_active_channel(act_ch), .o_active_setup(act_setup),
		.o_active_filter(act_filter), .o_internal_ref_on(iref), .o_open_wire_on(ow));
	adc_host_model adc_host_model_inst (.i_clk(i_clk), .i_sdo(sdo), .o_sclk(sclk),
		.o_sdi(sdi), .o_cs_n(cs_n));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	function automatic int len_of(input logic [5:0] r);
		if (r >= ADDR_OFFSET0) return 24;
		if (r inside {ADDR_ADC_MODE, ADDR_IF_MODE, ADDR_ID} || r >= ADDR_CHANNEL0) return 16;
		return 8;
	endfunction
	function automatic logic [31:0] rst_of(input logic [5:0] r);
		if (r >= ADDR_GAIN0) return {8'h00, GAIN_RESET};
		if (r >= ADDR_OFFSET0) return {8'h00, OFFSET_RESET};
		if (r >= ADDR_FILTER0) return {16'h0000, FILTER_RESET};
		if (r >= ADDR_SETUP0) return {16'h0000, SETUP_RESET};
		if (r > ADDR_CHANNEL0) return {16'h0000, CHANNELN_RESET};
		if (r == ADDR_CHANNEL0) return {16'h0000, CHANNEL0_RESET};
		if (r == ADDR_ADC_MODE) return {16'h0000, ADC_MODE_RESET};
		if (r == ADDR_ID) return {16'h0000, ID_VAL};
		return 32'h00000000;
	endfunction
	// low identity nibble is free, so it is never compared
	function automatic logic [31:0] mask_of(input logic [5:0] r);
		if (r == ADDR_ID) return 32'h0000fff0;
		if (r >= ADDR_OFFSET0) return 32'h00ffffff;
		if (r >= ADDR_FILTER0) return 32'h00008f7f;
		if (r >= ADDR_SETUP0) return 32'h00001f30;
		if (r >= ADDR_CHANNEL0) return 32'h0000f3ff;
		return 32'h0000ffff;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s: expected %h got %h", $time, what, exp, got);
		end
	endtask
	task automatic clear_shadow();
		foreach (shadow[i]) shadow[i] = rst_of(6'(i));
	endtask
	task automatic wr(input logic [5:0] r, input logic [31:0] d);
		adc_host_model_inst.sel(1'b1);
		adc_host_model_inst.shift(8, {56'h0, 2'b00, r}, rx);
		adc_host_model_inst.shift(len_of(r), 64'(d), rx);
		adc_host_model_inst.sel(1'b0);
		if (r >= ADDR_CHANNEL0 || r inside {ADDR_ADC_MODE, ADDR_IF_MODE}) shadow[r] = d & mask_of(r);
	endtask
	task automatic rd(input logic [5:0] r);
		adc_host_model_inst.sel(1'b1);
		adc_host_model_inst.shift(8, {56'h0, 2'b01, r}, rx);
		adc_host_model_inst.shift(len_of(r), '0, rx);
		adc_host_model_inst.sel(1'b0);
		chk("register read", shadow[r] & mask_of(r), rx[31:0] & mask_of(r));
	endtask
	task automatic ones(input int n);
		adc_host_model_inst.sel(1'b1);
		adc_host_model_inst.shift(n, '1, rx);
		adc_host_model_inst.sel(1'b0);
	endtask
	task automatic step_seq(input logic [3:0] ch, input logic [5:0] s);
		@(posedge i_clk);
		i_sample_done <= 1'b1;
		@(posedge i_clk);
		i_sample_done <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk("active channel", 32'(ch), 32'(act_ch));
		chk("active setup", shadow[ADDR_SETUP0 + s], 32'(act_setup));
		chk("active filter", shadow[ADDR_FILTER0 + s], 32'(act_filter));
		chk("internal reference", 32'(s == 6'h02), 32'(iref));
		chk("channel valid", 32'h00000001, 32'(valid));
		chk("sdo released", 32'h00000003, {30'h0, oe_n, sdo});
		chk("open wire", 32'h00000000, 32'(ow));
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#900000;
		miscompares++;
		final_report();
	end
	initial begin
		i_rst = 1'b1;
		i_sample_done = 1'b0;
		miscompares = 0;
		n_tests = 0;
		clear_shadow();
		void'($urandom(14));
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clk);
		ones(64);
		foreach (rlist[i]) rd(rlist[i]);
		$display("reset values done");
		wr(ADDR_ID, 32'h0000ffff);
		wr(6'h05, 32'h000000a5);
		rd(ADDR_ID);
		rd(6'h05);
		for (int i = 0; i < 20; i++) begin
			a = 6'($urandom_range(63, 17));
			wr(a, $urandom & mask_of(a));
			rd(a);
		end
		$display("random access done");
		// ignored command, then write and read-back in one frame
		adc_host_model_inst.sel(1'b1);
		adc_host_model_inst.shift(8, 64'h91, rx);
		adc_host_model_inst.shift(24, 64'h118123, rx);
		adc_host_model_inst.shift(24, 64'h510000, rx);
		adc_host_model_inst.sel(1'b0);
		shadow[6'h11] = 32'h00008123;
		chk("back to back", 32'h00008123, 32'(rx[15:0]));
		adc_host_model_inst.sel(1'b1);
		adc_host_model_inst.shift(16, 64'h12ff, rx);
		adc_host_model_inst.sel(1'b0);
		rd(6'h12);
		ones(63);
		rd(6'h11);
		$display("framing done");
		for (int k = 1; k < 16; k++) wr(6'(16 + k), k == 3 ? 32'ha000 : k == 9 ? 32'h8000 : 0);
		wr(ADDR_SETUP0, 32'(SETUP_RESET));
		wr(6'h22, 32'h1b20);
		wr(6'h2a, 32'h0009);
		step_seq(4'h3, 6'h02);
		step_seq(4'h9, 6'h00);
		step_seq(4'h0, 6'h00);
		step_seq(4'h3, 6'h02);
		$display("sequencer done");
		// setup 2 moved to the external reference, then the mode bit alone turns it on
		wr(6'h22, 32'h00001b00);
		chk("active setup", shadow[6'h22], 32'(act_setup));
		chk("internal reference", 32'h00000000, 32'(iref));
		wr(ADDR_ADC_MODE, 32'h00008000);
		chk("internal reference", 32'h00000001, 32'(iref));
		rd(ADDR_ADC_MODE);
		wr(ADDR_IF_MODE, $urandom & 32'h0000ffff);
		rd(ADDR_IF_MODE);
		$display("mode registers done");
		ones(64);
		clear_shadow();
		rd(ADDR_ADC_MODE);
		rd(ADDR_IF_MODE);
		rd(6'h11);
		rd(6'h22);
		chk("channel after link reset", 32'h0, 32'(act_ch));
		$display("link reset done");
		final_report();
	end
endmodule
